// File: hw/ifs_pkg.sv
// Constants shared by the input format and sync strobe block.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
package ifs_pkg;
  // ****
  // Sizes
  // ****
  localparam int NUM_CH = 4;
  localparam int BUS_W  = 17;
  localparam int SYNC_N = 2;
  // ****
  // Register indices; byte address is four times the index
  // ****
  localparam int IDX_TEST_DATA = 'h0002;
  localparam int IDX_TEST_STRB = 'h0003;
  localparam int IDX_SYNC_STRB = 'h0004;
  localparam int IDX_LOOP_STRB = 'h0005;
  localparam int IDX_HARD_RST  = 'h0006;
  localparam int IDX_FMT_BASE  = 'h0020;
  localparam int IDX_CTRL_BASE = 'h0024;
  localparam int IDX_SOFT_RST  = 'h0028;
  localparam int IDX_STATUS    = 'h002c;
  localparam logic [11:0] A_TEST_DATA = 12'(IDX_TEST_DATA * 4);
  localparam logic [11:0] A_TEST_STRB = 12'(IDX_TEST_STRB * 4);
  localparam logic [11:0] A_SYNC_STRB = 12'(IDX_SYNC_STRB * 4);
  localparam logic [11:0] A_LOOP_STRB = 12'(IDX_LOOP_STRB * 4);
  localparam logic [11:0] A_HARD_RST  = 12'(IDX_HARD_RST * 4);
  localparam logic [11:0] A_FMT_BASE  = 12'(IDX_FMT_BASE * 4);
  localparam logic [11:0] A_CTRL_BASE = 12'(IDX_CTRL_BASE * 4);
  localparam logic [11:0] A_SOFT_RST  = 12'(IDX_SOFT_RST * 4);
  localparam logic [11:0] A_STATUS    = 12'(IDX_STATUS * 4);
  // ****
  // Field positions and reset values
  // ****
  localparam int FMT_INV_CLK  = 13;
  localparam int FMT_CLK_SRC  = 12;
  localparam int FMT_OFFS_BIN = 11;
  localparam int FMT_INTERP   = 10;
  localparam int FMT_DMX_LSB  = 7;
  localparam int FMT_SWAP     = 4;
  localparam int FMT_MODE_LSB = 2;
  localparam int TD_EXP_LSB   = 16;
  localparam int TD_OUTEN_LSB = 20;
  localparam int CTRL_TSRC    = 2;
  localparam logic [15:0] FMT_RESET  = 16'h0000;
  localparam logic [31:0] TD_RESET   = 32'h0000_0000;
  localparam logic [2:0]  CTRL_RESET = 3'h0;
  // ****
  // Encodings
  // ****
  localparam logic [1:0] NUM_FIXED = 2'h0;
  localparam logic [1:0] NUM_F14   = 2'h1;
  localparam logic [1:0] NUM_F15   = 2'h2;
  localparam logic [1:0] EN_ALWAYS = 2'h0;
  localparam logic [1:0] EN_TEST   = 2'h2;
endpackage

// File: hw/ifs_chan_if.sv
// Bundle between the register file and one channel formatter.
// Assumes both ends run on the processing clock.
`timescale 1ns/10ps
interface ifs_chan_if;
  logic [15:0] fmt;       // Channel input format register.
  logic [2:0]  ctrl;      // Enable mode and test source select.
  logic [15:0] tdata;     // Test input data.
  logic [2:0]  texp;      // Test input exponent.
  logic        test_en;   // One-cycle test input enable.
  logic        soft_rst;  // Channel soft reset pulse.
  logic        hard_rst;  // Software hard reset pulse.
  logic        port_c;    // Port always clocked by processing clock.
  logic        clk_s;     // Synchronised port clock level.
  logic [16:0] data_s;    // Synchronised port data.
  logic [15:0] mant;      // Formatted mantissa.
  logic [2:0]  exp;       // Formatted exponent.
  logic        valid;     // Output sample strobe.
  logic        armed;     // Waiting for a delayed sample.
  modport regs (output fmt, ctrl, tdata, texp, test_en, soft_rst,
                hard_rst, port_c, clk_s, data_s,
                input mant, exp, valid, armed);
  modport chan (input fmt, ctrl, tdata, texp, test_en, soft_rst,
                hard_rst, port_c, clk_s, data_s,
                output mant, exp, valid, armed);
endinterface // ifs_chan_if

// File: hw/ifs_sync_strobe.sv
// Sync output pulse, loopback and sync input capture.
// Assumes sync inputs are pins; they pass two synchroniser flip-flops, then an output register.
`timescale 1ns/10ps
module ifs_sync_strobe
  import ifs_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_clk_en,
  // Strobe requests from the register file
  input  wire logic i_sync_req,
  input  wire logic i_loop_req,
  // Pins
  input  wire logic i_sync_in_one,
  input  wire logic i_sync_in_two,
  output logic      o_sync_out,
  output logic      o_sync_one_evt,
  output logic      o_sync_two_evt
);
  logic [SYNC_N-1:0] one_q;   // Pin one synchroniser.
  logic [SYNC_N-1:0] two_q;   // Pin two synchroniser.
  logic [SYNC_N-1:0] loop_q;  // Loopback delay, matches pin path.
  logic              lp_q;    // Loopback pulse beside the pin pulse.

  // ****
  // Output pulse and matched loopback
  // ****
  // The loopback goes through as many stages as the external wire does,
  // so both copies of the pulse reach the sync input together.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sync_out <= 1'b0;
      lp_q       <= 1'b0;
      loop_q     <= '0;
    end else if (i_clk_en) begin
      o_sync_out <= i_sync_req | i_loop_req;
      lp_q       <= i_loop_req;
      loop_q     <= {loop_q[SYNC_N-2:0], lp_q};
    end
  end

  // Pin capture; only the last stage is read by logic.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      one_q          <= '0;
      two_q          <= '0;
      o_sync_one_evt <= 1'b0;
      o_sync_two_evt <= 1'b0;
    end else if (i_clk_en) begin
      one_q          <= {one_q[SYNC_N-2:0], i_sync_in_one};
      two_q          <= {two_q[SYNC_N-2:0], i_sync_in_two};
      o_sync_one_evt <= one_q[SYNC_N-1] | loop_q[SYNC_N-1];
      o_sync_two_evt <= two_q[SYNC_N-1];
    end
  end

  a_sync_out_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_sync_req && i_clk_en) |=> o_sync_out)
    else $error("sync output pulse missing");
  a_loop_latency: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (lp_q && i_clk_en ##1 i_clk_en ##1 i_clk_en) |=> o_sync_one_evt)
    else $error("loopback latency wrong");
endmodule // ifs_sync_strobe

// File: hw/ifs_chan_fmt.sv
// One channel input formatter: edge select, enable, demux delay,
// bit swap, number format. Assumes synchronised port inputs.
`timescale 1ns/10ps
module ifs_chan_fmt
  import ifs_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_clk_en,
  // Register side
  ifs_chan_if.chan  ch
);
  logic        prev_q;   // Port clock level one cycle ago.
  logic        pend_q;   // Test enable waiting for a sample.
  logic [2:0]  cnt_q;    // Samples left before the take.
  logic [15:0] held_m_q; // Last taken mantissa.
  logic [2:0]  held_e_q; // Last taken exponent.
  logic        have_q;   // A sample has been taken.
  logic        smp, en_now, take, arm, clr;
  logic [2:0]  dly;
  logic [16:0] w;
  logic [15:0] m;
  logic [2:0]  e;

  // ****
  // Sample event, enable and word formatting
  // ****
  always_comb begin
    dly = ch.fmt[FMT_DMX_LSB +: 3];
    clr = ch.soft_rst | ch.hard_rst;
    // Processing processing clock edge is used when selected, on port C, or when the test source is selected.
    if (ch.fmt[FMT_CLK_SRC] || ch.port_c || ch.ctrl[CTRL_TSRC]) begin
      smp = 1'b1;
    end else if (ch.fmt[FMT_INV_CLK]) begin
      smp = prev_q & ~ch.clk_s;
    end else begin
      smp = ~prev_q & ch.clk_s;
    end
    case (ch.ctrl[1:0])
      EN_ALWAYS: en_now = 1'b1;
      EN_TEST:   en_now = pend_q | ch.test_en;
      default:   en_now = 1'b0;
    endcase
    take = smp & (ch.armed ? (cnt_q == 3'h1) : (en_now && dly == 3'h0));
    arm  = smp & ~ch.armed & en_now & (dly != 3'h0);
    w = ch.data_s;
    if (ch.fmt[FMT_SWAP]) begin
      for (int b = 0; b < BUS_W; b++) begin
        w[b] = ch.data_s[BUS_W-1-b];
      end
    end
    w[16] = w[16] ^ ch.fmt[FMT_OFFS_BIN];
    case (ch.fmt[FMT_MODE_LSB +: 2])
      NUM_FIXED: begin m = w[16:1]; e = 3'h0; end
      NUM_F14:   begin m = {w[16:3], 2'h0}; e = w[2:0]; end
      NUM_F15:   begin m = {w[16:2], 1'h0}; e = {1'h0, w[1:0]}; end
      default:   begin m = w[16:1]; e = {2'h0, w[0]}; end
    endcase
    if (ch.ctrl[CTRL_TSRC]) begin
      m = ch.tdata;
      e = ch.texp;
    end
  end

  // ****
  // Channel state; soft reset clears only this active state
  // ****
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q   <= 1'b0;
      pend_q   <= 1'b0;
      cnt_q    <= 3'h0;
      ch.armed <= 1'b0;
      held_m_q <= 16'h0000;
      held_e_q <= 3'h0;
      have_q   <= 1'b0;
      ch.mant  <= 16'h0000;
      ch.exp   <= 3'h0;
      ch.valid <= 1'b0;
    end else if (i_clk_en) begin
      prev_q <= ch.clk_s;
      if (clr) begin
        pend_q   <= 1'b0;
        cnt_q    <= 3'h0;
        ch.armed <= 1'b0;
        have_q   <= 1'b0;
        ch.valid <= 1'b0;
      end else begin
        pend_q <= (pend_q | ch.test_en) & ~smp;
        if (arm) begin
          ch.armed <= 1'b1;
          cnt_q    <= dly;
        end else if (smp && ch.armed) begin
          cnt_q    <= cnt_q - 3'h1;
          ch.armed <= cnt_q != 3'h1;
        end
        if (take) begin
          held_m_q <= m;
          held_e_q <= e;
          have_q   <= 1'b1;
        end
        // Interpolated output repeats the held sample between enables.
        ch.valid <= take | (smp & ch.fmt[FMT_INTERP] & have_q);
        ch.mant  <= take ? m : held_m_q;
        ch.exp   <= take ? e : held_e_q;
      end
    end
  end

  a_gated_valid: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !clr && !take && !ch.fmt[FMT_INTERP]) |=> !ch.valid)
    else $error("gated channel gave sample without take");
  a_demux_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !clr && smp && !ch.armed && en_now && dly == 3'h0) |=> ch.valid)
    else $error("aligned sample not taken");
endmodule // ifs_chan_fmt

// File: hw/ifs_top.sv
// Global strobes, test observation routing and per-channel input
// formatting. Assumes an APB master on the processing clock and
// converter buses with their own clocks arriving on pins.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps

// Notes on behaviour
// - Observation bits 8:4 from oscillator, gain strobes
// - Observation bits 2:0 carry buffer address
// - Enabled observation bus ORed onto output bus
// - Test strobe write gives one-cycle enable
// - Sync strobe write gives one-cycle output pulse
// - Loopback strobe pulses pin and sync one
// - Loopback latency equals external wire latency
// - Hard reset strobe resets control registers
// - Soft reset clears only selected channel state
// - Bit 13 selects falling sample edge
// - Bit 12 selects processing clock; port C always
// - Processing always on processing clock rising edge
// - Bit 11 selects offset binary input
// - Bit 10 interpolates, otherwise gated
// - Demux delay takes Nth sample after enable
// - Bit 4 reverses input bus order
// - Mode field selects fixed or floating layout
// - Enable always, never, or per test strobe
// - Test register supplies data and exponent
module ifs_top
  import ifs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clk_en,
  // APB slave
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [11:0]  i_paddr,
  input  wire logic [31:0]  i_pwdata,
  output logic      [31:0]  o_prdata,
  output logic              o_pready,
  output logic              o_pslverr,
  // Converter ports A, B, C, D (C has no clock pin)
  input  wire logic         i_port_a_clk,
  input  wire logic         i_port_b_clk,
  input  wire logic         i_port_d_clk,
  input  wire logic [67:0]  i_port_data,
  // Synchronisation pins
  input  wire logic         i_sync_in_one,
  input  wire logic         i_sync_in_two,
  output logic              o_sync_out,
  output logic              o_sync_one_evt,
  output logic              o_sync_two_evt,
  // Observation sources, four buses
  input  wire logic [27:0]  i_obs_range,
  input  wire logic [3:0]   i_obs_osc_carry,
  input  wire logic [15:0]  i_obs_gain_strb,
  input  wire logic [3:0]   i_obs_carrier_msb,
  input  wire logic [11:0]  i_obs_buf_addr,
  input  wire logic [63:0]  i_norm_out,
  output logic      [63:0]  o_out_bus,
  // Channel results and test enable
  output logic              o_test_en,
  output logic      [63:0]  o_chan_mant,
  output logic      [11:0]  o_chan_exp,
  output logic      [3:0]   o_chan_valid
);
  // ****
  // Declarations
  // ****
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,           // Waiting for an access phase.
    ST_RESP = 2'b10            // Answer presented with ready.
  } ifs_apb_st_t;

  ifs_apb_st_t state_q;        // APB answer state.
  logic [15:0] fmt_q [NUM_CH]; // Channel input format registers.
  logic [2:0]  ctrl_q [NUM_CH];// Channel enable mode and source.
  logic [31:0] tdata_q;        // Test input data register.
  logic [3:0]  soft_q;         // Channel soft reset pulses.
  logic        hard_q;         // Software hard reset pulse.
  logic        sync_req_q;     // Sync strobe request pulse.
  logic        loop_req_q;     // Loopback strobe request pulse.
  logic [17:0] pin1_q [NUM_CH];// First synchroniser stage.
  logic [17:0] pin2_q [NUM_CH];// Second synchroniser stage.
  logic [3:0]  armed_w;        // Channel waiting flags.
  logic [3:0]  clk_pins;       // Port clock pins, C tied low.
  logic        wr_fire;        // Write takes effect this edge.
  logic [31:0] rd_data;        // Decoded read data.
  logic        rd_err;         // Unmapped address.
  logic [1:0]  sel;            // Channel index from the address.

  assign clk_pins = {i_port_d_clk, 1'b0, i_port_b_clk, i_port_a_clk};
  assign wr_fire  = (state_q == ST_RESP) & i_psel & i_penable & i_pwrite;
  assign sel      = i_paddr[3:2];

  // ****
  // Address decode and read mux
  // ****
  // Unmapped addresses answer with an error and read zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case ({i_paddr[11:4], 4'h0})
      A_FMT_BASE:  rd_data = {16'h0000, fmt_q[sel]};
      A_CTRL_BASE: rd_data = {29'h0, ctrl_q[sel]};
      default: begin
        case (i_paddr)
          A_TEST_DATA: rd_data = tdata_q;
          A_STATUS:    rd_data = {28'h0, armed_w};
          // Strobes read back zero; they hold nothing.
          A_TEST_STRB, A_SYNC_STRB, A_LOOP_STRB, A_HARD_RST,
          A_SOFT_RST:  rd_data = 32'h0000_0000;
          default:     rd_err = 1'b1;
        endcase
      end
    endcase
    if (i_paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end
  end

  // ****
  // APB handshake
  // ****
  // One wait state: ready rises the cycle after the access phase
  // starts, and the write lands on that ready edge.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q   <= ST_IDLE;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else if (i_clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (i_psel && i_penable) begin
            state_q   <= ST_RESP;
            o_pready  <= 1'b1;
            o_pslverr <= rd_err;
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_data;
          end
        end
        ST_RESP: begin
          state_q   <= ST_IDLE;
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****
  // Write strobes
  // ****
  // Only the occurrence of the write matters; the data is ignored.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_test_en  <= 1'b0;
      sync_req_q <= 1'b0;
      loop_req_q <= 1'b0;
      hard_q     <= 1'b0;
    end else if (i_clk_en) begin
      o_test_en  <= wr_fire && !rd_err && i_paddr == A_TEST_STRB;
      sync_req_q <= wr_fire && !rd_err && i_paddr == A_SYNC_STRB;
      loop_req_q <= wr_fire && !rd_err && i_paddr == A_LOOP_STRB;
      hard_q     <= wr_fire && !rd_err && i_paddr == A_HARD_RST;
    end
  end

  // ****
  // Control registers
  // ****
  // The hard reset strobe clears them as the pin does, one cycle
  // after the write; soft resets never touch them.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tdata_q <= TD_RESET;
      soft_q  <= 4'h0;
      for (int c = 0; c < NUM_CH; c++) begin
        fmt_q[c]  <= FMT_RESET;
        ctrl_q[c] <= CTRL_RESET;
      end
    end else if (i_clk_en) begin
      soft_q <= 4'h0;
      if (hard_q) begin
        tdata_q <= TD_RESET;
        for (int c = 0; c < NUM_CH; c++) begin
          fmt_q[c]  <= FMT_RESET;
          ctrl_q[c] <= CTRL_RESET;
        end
      end else if (wr_fire && !rd_err) begin
        if ({i_paddr[11:4], 4'h0} == A_FMT_BASE) begin
          fmt_q[sel] <= i_pwdata[15:0];
        end else if ({i_paddr[11:4], 4'h0} == A_CTRL_BASE) begin
          ctrl_q[sel] <= i_pwdata[2:0];
        end else if (i_paddr == A_TEST_DATA) begin
          tdata_q <= i_pwdata;
        end else if (i_paddr == A_SOFT_RST) begin
          soft_q <= i_pwdata[3:0];
        end
      end
    end
  end

  // ****
  // Per-channel pin capture, formatter and output bus
  // ****
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    ifs_chan_if u_if ();
    logic [15:0] obs; // Observation bus for this lane.

    // Two stages per pin; the formatter reads only the second.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        pin1_q[i] <= 18'h00000;
        pin2_q[i] <= 18'h00000;
      end else if (i_clk_en) begin
        pin1_q[i] <= {clk_pins[i], i_port_data[17*i +: 17]};
        pin2_q[i] <= pin1_q[i];
      end
    end

    assign u_if.fmt      = fmt_q[i];
    assign u_if.ctrl     = ctrl_q[i];
    assign u_if.tdata    = tdata_q[15:0];
    assign u_if.texp     = tdata_q[TD_EXP_LSB +: 3];
    assign u_if.test_en  = o_test_en;
    assign u_if.soft_rst = soft_q[i];
    assign u_if.hard_rst = hard_q;
    assign u_if.port_c   = (i == 2);
    assign u_if.clk_s    = pin2_q[i][17];
    assign u_if.data_s   = pin2_q[i][16:0];
    assign armed_w[i]    = u_if.armed;
    assign o_chan_mant[16*i +: 16] = u_if.mant;
    assign o_chan_exp[3*i +: 3]    = u_if.exp;
    assign o_chan_valid[i]         = u_if.valid;

    ifs_chan_fmt u_fmt (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_clk_en   (i_clk_en),
      .ch         (u_if.chan)
    );

    // Lane layout: range flags, oscillator carry, gain strobes,
    // carrier top bit, buffer read address.
    assign obs = {i_obs_range[7*i +: 7], i_obs_osc_carry[i],
                  i_obs_gain_strb[4*i +: 4], i_obs_carrier_msb[i],
                  i_obs_buf_addr[3*i +: 3]};

    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        o_out_bus[16*i +: 16] <= 16'h0000;
      end else if (i_clk_en) begin
        o_out_bus[16*i +: 16] <= i_norm_out[16*i +: 16] |
          (tdata_q[TD_OUTEN_LSB + i] ? obs : 16'h0000);
      end
    end
  end

  // ****
  // Sync strobes
  // ****
  ifs_sync_strobe u_sync (
    .i_core_clk     (i_core_clk),
    .i_rst          (i_rst),
    .i_clk_en       (i_clk_en),
    .i_sync_req     (sync_req_q),
    .i_loop_req     (loop_req_q),
    .i_sync_in_one  (i_sync_in_one),
    .i_sync_in_two  (i_sync_in_two),
    .o_sync_out     (o_sync_out),
    .o_sync_one_evt (o_sync_one_evt),
    .o_sync_two_evt (o_sync_two_evt)
  );

  // ****
  // Checks
  // ****
  a_test_strobe_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_fire && i_paddr == A_TEST_STRB) |=> o_test_en ##1 !o_test_en)
    else $error("test enable not one cycle");
  a_loop_pin_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_fire && i_paddr == A_LOOP_STRB ##1 i_clk_en) |=> o_sync_out)
    else $error("loopback strobe gave no pin pulse");
  a_hard_reset_regs: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (hard_q && i_clk_en) |=> (fmt_q[0] == FMT_RESET && tdata_q == TD_RESET))
    else $error("hard reset left control state");
  a_soft_keeps_fmt: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (soft_q[0] && !hard_q) |=> $stable(fmt_q[0]))
    else $error("soft reset touched control register");
  a_obs_carry_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && tdata_q[TD_OUTEN_LSB] && i_obs_osc_carry[0]) |=> o_out_bus[8])
    else $error("carry not on bit 8");
  a_obs_gated_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !tdata_q[TD_OUTEN_LSB]) |=> o_out_bus[15:0] == $past(i_norm_out[15:0]))
    else $error("observation leaked while disabled");
endmodule // ifs_top

// File: tb/ifs_src_model.sv
// Converter-side model: port clock bursts and sync pin pulses.
// Assumes the bench requests sync pulses on the processing clock.
`timescale 1ns/10ps
module ifs_src_model (
  // Control from the bench
  input  wire logic i_core_clk,
  input  wire logic i_run,
  input  wire logic i_pulse,
  // Pins toward the block
  output logic      o_port_clk,
  output logic      o_sync
);
  // The converter clock stands low outside a burst.
  initial begin
    o_port_clk = 1'b0;
    forever #40 o_port_clk = i_run ? ~o_port_clk : 1'b0;
  end
  // One clock wide, launched just after a rising edge.
  always @(posedge i_core_clk) o_sync <= i_pulse;
endmodule // ifs_src_model

// File: tb/ifs_top_test.sv
// Self-checking bench for the strobe and input format block.
// Assumes the source model drives the port clocks and sync one.
`timescale 1ns/10ps
module ifs_top_test;
  import ifs_pkg::*;
  // ****
  // Signals
  // ****
  logic        clk, rst, psel, pen, pwr, run, pulse, pready, perr;
  logic        sout, e1, e2, pclk, sync1, ten;
  logic [11:0] addr, ba;
  logic [31:0] wd, prdata, failures, checks_done, ns, nt, base, t0, dly;
  logic [31:0] seed = 32'h32;     // Fixed seed.
  logic [27:0] rng;
  logic [3:0]  car, cm, vld;
  logic [15:0] gn;
  // Fixed, offset binary, swapped, float 14/3, falling edge, interpolated
  // with a demux delay of one sample.
  logic [15:0] fmts [6] = '{16'h4000, 16'h4800, 16'h4010, 16'h4004, 16'h6000, 16'h4480};
  logic [63:0] norm, outb, mant;
  logic [11:0] ex;
  logic [67:0] pdat;
  logic [31:0] q [$];             // Expected read data, oldest first.
  int          i;
  ifs_top ifs_top_inst (.i_core_clk(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .i_port_a_clk(pclk), .i_port_b_clk(pclk), .i_port_d_clk(pclk),
    .i_port_data(pdat), .i_sync_in_one(sync1), .i_sync_in_two(1'b0),
    .o_sync_out(sout), .o_sync_one_evt(e1), .o_sync_two_evt(e2),
    .i_obs_range(rng), .i_obs_osc_carry(car), .i_obs_gain_strb(gn),
    .i_obs_carrier_msb(cm), .i_obs_buf_addr(ba), .i_norm_out(norm),
    .o_out_bus(outb), .o_test_en(ten), .o_chan_mant(mant),
    .o_chan_exp(ex), .o_chan_valid(vld));
  ifs_src_model ifs_src_model_inst (.i_core_clk(clk), .i_run(run),
    .i_pulse(pulse), .o_port_clk(pclk), .o_sync(sync1));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected mantissa: k 1 offset binary, 2 swapped, 3 float 14/3.
  function automatic logic [15:0] fx(input logic [16:0] d, input int k);
    logic [16:0] r;
    r = d;
    if (k == 2) r = {<<{d}};
    if (k == 3) return {r[16:3], 2'b00};
    return r[16:1] ^ ((k == 1) ? 16'h8000 : 16'h0000);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic stop_test(input logic to);
    if (to) failures++;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait on channel c valid, or on pready for c of 4.
  task automatic wt(input int c);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if ((c == 4 ? pready : vld[c]) === 1'b1) break;
    end
    if (n == 200) stop_test(1'b1);
  endtask
  // Request held until pready is sampled high, then released.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, addr, wd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    wt(4);
    {psel, pen} <= 2'b00;
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // ****
  // Clock, monitor and sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Read data is compared with the oldest note; pulses are counted.
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1 && q.size() > 0) chk(prdata, q.pop_front());
    if (psel && pen && pready === 1'b1) chk(32'(perr), 32'(addr == 12'h7fc));
    if (sout === 1'b1 || sync1 === 1'b1) t0 = 32'($time);
    if (e1 === 1'b1) dly = 32'($time) - t0;
    ns += 32'(sout === 1'b1);
    nt += 32'(ten === 1'b1);
  end
  initial begin
    {rst, psel, pen, pwr, run, pulse, addr, wd} = {6'h20, 44'h0};
    {failures, checks_done, ns, nt} = '0;
    {rng, car, gn, cm, ba, norm} = {xs(), xs(), xs(), xs()};
    pdat = {4{17'(xs())}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdx(A_FMT_BASE, 32'h0);
    rdx(12'h7fc, 32'h0);
    base = ns;
    apb(1'b1, A_SYNC_STRB, xs());
    repeat (6) @(posedge clk);
    chk(ns - base, 32'h1);
    apb(1'b1, A_LOOP_STRB, xs());
    repeat (6) @(posedge clk);
    chk(ns - base, 32'h2);
    chk(dly, 32'd15);
    pulse <= 1'b1;
    @(posedge clk);
    pulse <= 1'b0;
    repeat (6) @(posedge clk);
    chk(dly, 32'd15);
    $display("sync test done");
    apb(1'b1, A_TEST_DATA, 32'h0015_1234);
    apb(1'b1, A_CTRL_BASE + 12'h4, 32'h6);
    base = nt;
    apb(1'b1, A_TEST_STRB, xs());
    wt(1);
    chk(32'(mant[31:16]), 32'h1234);
    chk(32'(ex[5:3]), 32'h5);
    chk(nt - base, 32'h1);
    {rng, car, gn, cm, ba, norm} <= {xs(), xs(), xs(), xs()};
    repeat (4) @(posedge clk);
    chk(32'(outb[15:0]), 32'(norm[15:0] | {rng[6:0], car[0], gn[3:0], cm[0], ba[2:0]}));
    chk(outb[47:16], norm[47:16]);
    $display("test input done");
    apb(1'b1, A_FMT_BASE, 32'h4010);
    rdx(A_FMT_BASE, 32'h4010);
    apb(1'b1, A_HARD_RST, xs());
    rdx(A_FMT_BASE, 32'h0);
    rdx(A_TEST_DATA, 32'h0);
    $display("hard reset done");
    run <= 1'b1;
    for (i = 0; i < 6; i++) begin
      apb(1'b1, A_FMT_BASE, 32'(fmts[i]));
      wt(0);
      wt(0);
      chk(32'(mant[15:0]), 32'(fx(pdat[16:0], i)));
    end
    run <= 1'b0;
    // A soft reset of channel 0 must leave its format register alone.
    apb(1'b1, A_SOFT_RST, 32'h1);
    rdx(A_FMT_BASE, 32'h4480);
    $display("format test done");
    stop_test(1'b0);
  end
endmodule // ifs_top_test
